// ### hdl/lpmc_top.sv
// low-power mode entry, wake-up, restart delays, sleep bus grants and interrupt levels
// Contract
// (R1) io halt plus sleep stops cpu and io
// (R2) system stop wakes only on combinational sources
// (R3) idle when io halt, standby 0, quick 1
// (R4) idle gates clock everywhere, oscillator runs
// (R5) idle exits on reset, nmi, enabled pins
// (R6) nmi or enabled irq with gie takes interrupt
// (R7) enabled irq without gie resumes after sleep
// (R8) idle restart takes about 9.5 clocks
// (R9) idle grants bus if enabled, 8 clocks slower
// (R10) bus request dropped returns to gated idle
// (R11) standby when io halt and standby bit
// (R12) standby exits on reset, nmi, pins; grants bus
// (R13) standby wake waits 131072 or 64 clocks
// (R14) standby bus grant waits same stabilisation count
// (R15) request dropped during stabilisation stays in standby
// (R16) external reset held until clock stable; sys_rst_in is used directly here, with no hold
// (R17) reset selects divide-by-two clocking
// (R18) external logic may stop clock in standby
// (R19) twelve interrupt priority levels provided
// (R20) shared level resolved by acknowledge daisy chain
// (R21) plain sleep when halt, quick, standby zero
// (R22) three enables, level zero set at reset
// (R23) disabled sources never wake the device
// (R24) stabilisation counter restarts on each request
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "lpmc_cfg.svh"

module lpmc_top #(
  parameter int STAB_LONG_CYC = `LPMC_STAB_LONG_CYC,
  parameter int DAISY_N = 4
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // ahb-lite slave
  input lpmc_pkg::lpmc_ahb_req_s ahb_req_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // external pins, active low interrupts
  input wire logic nmi_n_in,
  input wire logic [2:0] ext_irq_n_in,
  input wire logic bus_req_in,
  output logic bus_grant_out,
  output logic halt_n_out,
  // on-chip wake sources, same clock
  input wire logic onchip_irq_in,
  input wire logic onchip_comb_irq_in,
  // clock control
  output lpmc_pkg::lpmc_clk_gate_s clk_gate_out,
  output logic clk_div1_out,
  // wake results
  output logic wake_irq_out,
  output logic wake_resume_out,
  // interrupt levels
  input wire logic [7:0] dedicated_irq_in,
  input wire logic [DAISY_N-1:0] daisy_req_in,
  input wire logic daisy_ack_in,
  output logic [3:0] irq_level_out,
  output logic irq_pend_out,
  output logic [DAISY_N:0] daisy_grant_out
);
  import lpmc_pkg::*;

  localparam int LVL = `LPMC_LEVELS;
  localparam int CW = `LPMC_CNT_W;
  localparam logic [CW-1:0] STAB_LONG_T = CW'(STAB_LONG_CYC - 1);
  localparam logic [CW-1:0] STAB_QUICK_T = CW'(`LPMC_STAB_QUICK_CYC - 1);
  localparam logic [CW-1:0] IDLE_RST_T = CW'(`LPMC_IDLE_RESTART_CYC - 1);
  localparam logic [CW-1:0] SLEEP_RST_T = CW'(`LPMC_SLEEP_RESTART_CYC - 1);
  // entry edge, terminal compare and grant flop use three of the idle grant cycles
  localparam logic [CW-1:0] IDLE_GNT_T = CW'(`LPMC_GRANT_EXTRA_CYC + `LPMC_GRANT_NORM_CYC - 3);

  // lowest set index of a request vector, bit 0 wins
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] idx;
    idx = 5'h10;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
        idx = 5'(i);
    end
    return idx;
  endfunction

  // pin synchronisers
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      pin_meta_q <= 5'h0F;
      pin_sync_q <= 5'h0F;
    end
    else
    begin
      pin_meta_q <= {bus_req_in, nmi_n_in, ext_irq_n_in};
      pin_sync_q <= pin_meta_q;
    end
  end
  logic [2:0] ext_irq_act;
  logic nmi_act;
  logic bus_req_s;
  assign ext_irq_act = ~pin_sync_q[2:0];
  assign nmi_act = ~pin_sync_q[3];
  assign bus_req_s = pin_sync_q[4];

  // software registers
  logic io_halt_bit_q;
  logic [7:0] cpu_control_reg_q;
  logic [2:0] irq_trap_control_reg_q;
  logic global_irq_flag_q;
  logic sleep_instruction;
  logic ahb_pend_q;
  logic ahb_wr_q;
  logic [`LPMC_ADDR_MSB:0] ahb_addr_q;
  lpmc_state_e state_q;
  logic [CW-1:0] cnt_q;
  logic stab_bus_q;
  logic wake_nmi_q;
  logic take_irq_q;
  logic [1:0] cause_q;
  lpmc_state_e ret_state_q;

  wire logic stby_sel = cpu_control_reg_q[`LPMC_CPU_STBY_BIT];
  wire logic quick_sel = cpu_control_reg_q[`LPMC_CPU_QUICK_BIT];
  wire logic sleep_bus_grant_enable = cpu_control_reg_q[`LPMC_CPU_BUS_GNT_BIT];

  // one wait state per transfer so read data comes from a flop
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      ahb_pend_q <= 1'b0;
      ahb_wr_q <= 1'b0;
      ahb_addr_q <= '0;
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h0000_0000;
      hresp_out <= 1'b0;
    end
    else if (ahb_pend_q)
    begin
      ahb_pend_q <= 1'b0;
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h0000_0000;
      if (!ahb_wr_q)
      begin
        unique case ({{(31 - `LPMC_ADDR_MSB){1'b0}}, ahb_addr_q})
          `LPMC_OFS_IO_CTRL: hrdata_out <= 32'(io_halt_bit_q) << `LPMC_IO_HALT_BIT;
          `LPMC_OFS_CPU_CTRL: hrdata_out <= {24'h00_0000, cpu_control_reg_q};
          `LPMC_OFS_IRQ_CTRL: hrdata_out <= {29'h0000_0000, irq_trap_control_reg_q};
          `LPMC_OFS_GIE: hrdata_out <= {31'h0000_0000, global_irq_flag_q};
          `LPMC_OFS_STATUS: hrdata_out <= {24'h00_0000, bus_grant_out, take_irq_q, cause_q, 4'(state_q)};
          default: hrdata_out <= 32'h0000_0000;
        endcase
      end
    end
    else if (ahb_req_in.hsel && ahb_req_in.htrans[1] && hready_in)
    begin
      ahb_pend_q <= 1'b1;
      ahb_wr_q <= ahb_req_in.hwrite;
      ahb_addr_q <= ahb_req_in.haddr[`LPMC_ADDR_MSB:0];
      hreadyout_out <= 1'b0;
    end
  end

  wire logic wr_now = ahb_pend_q && ahb_wr_q;
  wire logic [31:0] wr_addr = {{(31 - `LPMC_ADDR_MSB){1'b0}}, ahb_addr_q};

  // control registers, divide-by-two at reset
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      io_halt_bit_q <= 1'b0;
      cpu_control_reg_q <= `LPMC_CPU_CTRL_RST; // [R17]
      irq_trap_control_reg_q <= `LPMC_IRQ_CTRL_RST; // [R22]
      global_irq_flag_q <= 1'b0;
    end
    else if (wr_now)
    begin
      if (wr_addr == `LPMC_OFS_IO_CTRL)
        io_halt_bit_q <= hwdata_in[`LPMC_IO_HALT_BIT];
      if (wr_addr == `LPMC_OFS_CPU_CTRL)
        cpu_control_reg_q <= hwdata_in[7:0] & `LPMC_CPU_CTRL_MASK;
      if (wr_addr == `LPMC_OFS_IRQ_CTRL)
        irq_trap_control_reg_q <= hwdata_in[2:0];
      if (wr_addr == `LPMC_OFS_GIE)
        global_irq_flag_q <= hwdata_in[0];
    end
  end
  // sleep is only honoured while running
  assign sleep_instruction = wr_now && (wr_addr == `LPMC_OFS_SLEEP) && (state_q == ST_RUN);

  // wake qualification, disabled pins never count
  logic [2:0] pin_wake;
  logic ext_wake;
  assign pin_wake = ext_irq_act & irq_trap_control_reg_q; // [R23] [R5]
  assign ext_wake = |pin_wake;

  // mode state machine
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ST_RUN;
      ret_state_q <= ST_RUN;
      cnt_q <= '0;
      stab_bus_q <= 1'b0;
      wake_nmi_q <= 1'b0;
      take_irq_q <= 1'b0;
      cause_q <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        ST_RUN:
        begin
          if (sleep_instruction)
          begin
            cnt_q <= '0;
            if (!io_halt_bit_q)
              state_q <= ST_SLEEP; // [R21]
            else if (stby_sel)
              state_q <= ST_STANDBY; // [R11]
            else if (quick_sel)
              state_q <= ST_IDLE; // [R3]
            else
              state_q <= ST_SYSSTOP; // [R1]
          end
        end
        ST_SLEEP, ST_SYSSTOP:
        begin
          // system stop leaves only clockless peripheral requests
          if (nmi_act || ext_wake || onchip_comb_irq_in || (state_q == ST_SLEEP && onchip_irq_in)) // [R2]
          begin
            take_irq_q <= nmi_act || global_irq_flag_q;
            cause_q <= nmi_act ? 2'h1 : 2'h2;
            cnt_q <= SLEEP_RST_T;
            state_q <= ST_RESTART;
          end
        end
        ST_IDLE:
        begin
          if (nmi_act || ext_wake) // [R5]
          begin
            take_irq_q <= nmi_act || global_irq_flag_q; // [R6] [R7]
            cause_q <= nmi_act ? 2'h1 : 2'h2;
            cnt_q <= IDLE_RST_T; // [R8]
            state_q <= ST_RESTART;
          end
          else if (bus_req_s && sleep_bus_grant_enable) // [R9]
          begin
            cnt_q <= '0;
            ret_state_q <= ST_IDLE;
            state_q <= ST_IDLE_BUS_WAIT;
          end
        end
        ST_IDLE_BUS_WAIT:
        begin
          if (!bus_req_s)
            state_q <= ST_IDLE;
          else if (cnt_q == IDLE_GNT_T)
            state_q <= ST_BUS_GRANT; // [R9]
          else
            cnt_q <= cnt_q + CW'(1);
        end
        ST_BUS_GRANT:
        begin
          if (!bus_req_s)
          begin
            cnt_q <= '0;
            state_q <= ret_state_q; // [R10]
          end
        end
        ST_STANDBY:
        begin
          cnt_q <= '0;
          if (nmi_act || ext_wake) // [R12]
          begin
            stab_bus_q <= 1'b0;
            wake_nmi_q <= nmi_act;
            state_q <= ST_STBY_STAB;
          end
          else if (bus_req_s && sleep_bus_grant_enable) // [R12]
          begin
            stab_bus_q <= 1'b1;
            wake_nmi_q <= 1'b0;
            state_q <= ST_STBY_STAB;
          end
        end
        ST_STBY_STAB:
        begin
          // the figure counts restarted oscillator edges, so settling comes free
          if (!stab_bus_q && !wake_nmi_q && !ext_wake)
            state_q <= ST_STANDBY; // [R15]
          else if (stab_bus_q && !bus_req_s)
            state_q <= ST_STANDBY; // [R15]
          else if (cnt_q == (quick_sel ? STAB_QUICK_T : STAB_LONG_T)) // [R13] [R14] [R18]
          begin
            cnt_q <= '0;
            if (stab_bus_q)
            begin
              ret_state_q <= ST_STANDBY;
              state_q <= ST_BUS_GRANT; // [R14]
            end
            else
            begin
              take_irq_q <= wake_nmi_q || global_irq_flag_q; // [R6] [R7]
              cause_q <= wake_nmi_q ? 2'h1 : 2'h2;
              state_q <= ST_RUN;
            end
          end
          else
            cnt_q <= cnt_q + CW'(1); // [R24]
        end
        ST_RESTART:
        begin
          if (cnt_q == '0)
            state_q <= ST_RUN;
          else
            cnt_q <= cnt_q - CW'(1);
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  // wake result pulses on return to run
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      wake_irq_out <= 1'b0;
      wake_resume_out <= 1'b0;
    end
    else
    begin
      wake_irq_out <= 1'b0;
      wake_resume_out <= 1'b0;
      if ((state_q == ST_RESTART && cnt_q == '0) ||
          (state_q == ST_STBY_STAB && !stab_bus_q && (wake_nmi_q || ext_wake) &&
           cnt_q == (quick_sel ? STAB_QUICK_T : STAB_LONG_T)))
      begin
        wake_irq_out <= (state_q == ST_RESTART) ? take_irq_q : (wake_nmi_q || global_irq_flag_q); // [R6]
        wake_resume_out <= (state_q == ST_RESTART) ? !take_irq_q : !(wake_nmi_q || global_irq_flag_q); // [R7]
      end
    end
  end

  // clock gates follow the mode, one cycle behind
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b1, cpu_en: 1'b1, io_en: 1'b1, refresh_en: 1'b1};
      halt_n_out <= 1'b1;
      clk_div1_out <= 1'b0; // [R17]
    end
    else
    begin
      clk_div1_out <= cpu_control_reg_q[`LPMC_CPU_DIV1_BIT];
      halt_n_out <= (state_q == ST_RUN);
      unique case (state_q)
        ST_RUN:
          clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b1, cpu_en: 1'b1, io_en: !io_halt_bit_q, refresh_en: 1'b1};
        ST_SLEEP, ST_RESTART:
          clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b1, cpu_en: 1'b0, io_en: !io_halt_bit_q, refresh_en: 1'b0};
        ST_SYSSTOP:
          clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b1, cpu_en: 1'b0, io_en: 1'b0, refresh_en: 1'b0}; // [R1]
        ST_IDLE, ST_IDLE_BUS_WAIT:
          clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b0, cpu_en: 1'b0, io_en: 1'b0, refresh_en: 1'b0}; // [R4]
        ST_BUS_GRANT:
          clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b1, cpu_en: 1'b0, io_en: 1'b0, refresh_en: 1'b0};
        ST_STANDBY:
          clk_gate_out <= '{osc_en: 1'b0, phi_en: 1'b0, cpu_en: 1'b0, io_en: 1'b0, refresh_en: 1'b0}; // [R11]
        ST_STBY_STAB:
          clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b0, cpu_en: 1'b0, io_en: 1'b0, refresh_en: 1'b0};
        default:
          clk_gate_out <= '{osc_en: 1'b1, phi_en: 1'b1, cpu_en: 1'b1, io_en: 1'b1, refresh_en: 1'b1};
      endcase
    end
  end

  // bus grant: normal latency in run, sleep and system stop only
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      bus_grant_out <= 1'b0;
    else if (state_q == ST_RUN || state_q == ST_SLEEP || state_q == ST_SYSSTOP)
      bus_grant_out <= bus_req_s;
    else
      bus_grant_out <= (state_q == ST_BUS_GRANT) && bus_req_s; // [R9] [R14]
  end

  // priority levels: 0 nmi, 1 pin one, 2 pin two, 3..10 dedicated, 11 shared
  logic [LVL-1:0] lvl_req;
  logic shared_req;
  logic [4:0] lvl_idx;
  logic [4:0] daisy_idx;
  logic [15:0] daisy_vec;
  assign daisy_vec = 16'({ext_irq_act[0], daisy_req_in});
  assign shared_req = |daisy_vec;
  assign lvl_req[0] = nmi_act;
  assign lvl_req[1] = ext_irq_act[1] && irq_trap_control_reg_q[`LPMC_IRQ_PIN1_BIT] && global_irq_flag_q;
  assign lvl_req[2] = ext_irq_act[2] && irq_trap_control_reg_q[`LPMC_IRQ_PIN2_BIT] && global_irq_flag_q;
  assign lvl_req[10:3] = dedicated_irq_in & {8{global_irq_flag_q}};
  assign lvl_req[11] = shared_req && irq_trap_control_reg_q[`LPMC_IRQ_LVL0_BIT] && global_irq_flag_q;
  assign lvl_idx = first_set(16'(lvl_req)); // [R19]
  assign daisy_idx = first_set(daisy_vec); // [R20]

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      irq_level_out <= 4'h0;
      irq_pend_out <= 1'b0;
      daisy_grant_out <= '0;
    end
    else
    begin
      irq_pend_out <= |lvl_req; // [R19]
      irq_level_out <= lvl_idx[3:0];
      // on-chip chain ahead of the pin, lowest index nearest the cpu
      if (daisy_ack_in && !daisy_idx[4])
        daisy_grant_out <= (DAISY_N+1)'(1) << daisy_idx[3:0]; // [R20]
      else
        daisy_grant_out <= '0;
    end
  end

endmodule

// ### shared/lpmc_cfg.svh
// offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH

`define LPMC_OFS_IO_CTRL 32'h0000_0000
`define LPMC_OFS_CPU_CTRL 32'h0000_0004
`define LPMC_OFS_IRQ_CTRL 32'h0000_0008
`define LPMC_OFS_GIE 32'h0000_000C
`define LPMC_OFS_SLEEP 32'h0000_0010
`define LPMC_OFS_STATUS 32'h0000_0014
`define LPMC_ADDR_MSB 7

`define LPMC_IO_HALT_BIT 5
`define LPMC_CPU_DIV1_BIT 7
`define LPMC_CPU_STBY_BIT 6
`define LPMC_CPU_BUS_GNT_BIT 5
`define LPMC_CPU_QUICK_BIT 3
`define LPMC_CPU_CTRL_MASK 8'hE8
`define LPMC_CPU_CTRL_RST 8'h00
`define LPMC_IRQ_CTRL_RST 3'h1
`define LPMC_IRQ_LVL0_BIT 0
`define LPMC_IRQ_PIN1_BIT 1
`define LPMC_IRQ_PIN2_BIT 2

`define LPMC_LEVELS 12
`define LPMC_CLK_NS 50
`define LPMC_IDLE_RESTART_NS 475
`define LPMC_IDLE_RESTART_CYC ((`LPMC_IDLE_RESTART_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_SLEEP_RESTART_NS 75
`define LPMC_SLEEP_RESTART_CYC ((`LPMC_SLEEP_RESTART_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_GRANT_EXTRA_NS 400
`define LPMC_GRANT_EXTRA_CYC ((`LPMC_GRANT_EXTRA_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_GRANT_NORM_CYC 1
`define LPMC_STAB_QUICK_NS 3200
`define LPMC_STAB_QUICK_CYC ((`LPMC_STAB_QUICK_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_STAB_LONG_NS 6553600
`define LPMC_STAB_LONG_CYC ((`LPMC_STAB_LONG_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_CNT_W 18

`endif

// ### shared/lpmc_pkg.sv
// types shared by the power-mode controller
package lpmc_pkg;

  typedef enum logic [3:0] {
    ST_RUN,
    ST_SLEEP,
    ST_SYSSTOP,
    ST_IDLE,
    ST_IDLE_BUS_WAIT,
    ST_BUS_GRANT,
    ST_STANDBY,
    ST_STBY_STAB,
    ST_RESTART
  } lpmc_state_e;

  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
  } lpmc_ahb_req_s;

  typedef struct packed {
    logic osc_en;
    logic phi_en;
    logic cpu_en;
    logic io_en;
    logic refresh_en;
  } lpmc_clk_gate_s;

endpackage

// ### verification/lpmc_sva.sv
// port checker for the power-mode controller
`timescale 1ns/1ps
module lpmc_sva (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // bus
  input lpmc_pkg::lpmc_ahb_req_s ahb_req_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // pins and controls
  input wire logic bus_req_in,
  input wire logic bus_grant_out,
  input wire logic halt_n_out,
  input lpmc_pkg::lpmc_clk_gate_s clk_gate_out,
  input wire logic clk_div1_out,
  input wire logic wake_irq_out,
  input wire logic wake_resume_out
);
  import lpmc_pkg::*;
  logic [7:0] osc_cyc_q;
  logic was_off_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // cycles since oscillator restart, saturating so long runs stay cheap
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || !clk_gate_out.osc_en)
      osc_cyc_q <= 8'h00;
    else if (osc_cyc_q != 8'hFF)
      osc_cyc_q <= osc_cyc_q + 8'h01;
  end
  // set while asleep after an oscillator stop
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || halt_n_out)
      was_off_q <= 1'b0;
    else if (!clk_gate_out.osc_en)
      was_off_q <= 1'b1;
  end
  resp_okay_a: assert property (!hresp_out)
    else $error("response not okay");
  one_wait_a: assert property (ahb_req_in.hsel && ahb_req_in.htrans[1] && hready_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("wait state count wrong");
  one_cause_a: assert property (!(wake_irq_out && wake_resume_out))
    else $error("both wake pulses");
  div_reset_a: assert property ($fell(sys_rst_in) |-> !clk_div1_out)
    else $error("divide by one after reset");
  gated_halt_a: assert property (!clk_gate_out.phi_en |-> !halt_n_out)
    else $error("clock gated while running");
  grant_drop_a: assert property ($fell(bus_req_in) |-> ##[1:6] !bus_grant_out)
    else $error("grant held after request drop");
  pulse_run_a: assert property ((wake_irq_out || wake_resume_out) |-> ##[0:2] halt_n_out)
    else $error("wake pulse without restart");
  stby_wake_a: assert property ($rose(halt_n_out) && was_off_q |-> osc_cyc_q >= 8'h3E)
    else $error("standby wake too early");
  stby_grant_a: assert property ($rose(bus_grant_out) && was_off_q |-> osc_cyc_q >= 8'h3E)
    else $error("standby grant too early");
endmodule

bind lpmc_top lpmc_sva u_sva (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ahb_req_in(ahb_req_in),
  .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .bus_req_in(bus_req_in),
  .bus_grant_out(bus_grant_out), .halt_n_out(halt_n_out), .clk_gate_out(clk_gate_out),
  .clk_div1_out(clk_div1_out), .wake_irq_out(wake_irq_out), .wake_resume_out(wake_resume_out));

// ### verification/lpmc_far_end.sv
// far side model: interrupt sources and an external bus master
`timescale 1ns/1ps
module lpmc_far_end (
  // bench controls
  input wire logic clk_in,
  input wire logic [3:0] src_on_in,
  input wire logic bus_want_in,
  input wire logic [3:0] hold_in,
  input wire logic bus_grant_in,
  // device pins
  output logic nmi_n_out,
  output logic [2:0] ext_irq_n_out,
  output logic bus_req_out
);
  logic [3:0] held_q;
  // sources pull low while active; the clock is left running in standby
  assign nmi_n_out = !src_on_in[3];
  assign ext_irq_n_out = ~src_on_in[2:0];
  // master drops its request once it has used the bus hold_in cycles
  assign bus_req_out = bus_want_in && (held_q != hold_in);
  always @(posedge clk_in)
  begin
    if (!bus_want_in)
      held_q <= 4'h0;
    else if (bus_grant_in && held_q != hold_in)
      held_q <= held_q + 4'h1;
  end
endmodule

// ### verification/testbench.sv
// self-checking bench for the power-mode controller
`timescale 1ns/1ps
`include "lpmc_cfg.svh"
module testbench;
  import lpmc_pkg::*;
  logic clk, rst, hrdy, hresp, nmi_n, breq, bgnt, halt_n, div1, wirq, wres, onchip, comb, dack, pend, want;
  lpmc_ahb_req_s req;
  lpmc_clk_gate_s gates;
  logic [31:0] wdata, hrdata, q;
  logic [2:0] irq_n;
  logic [3:0] src, hold, lvl, dreq;
  logic [7:0] ded;
  logic [4:0] dgnt;
  int n_fail, tests_run, n, nr;
  // short long-recovery count keeps the run brief
  lpmc_top #(.STAB_LONG_CYC(100), .DAISY_N(4)) dut (.mclk_in(clk), .sys_rst_in(rst), .ahb_req_in(req),
    .hwdata_in(wdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .nmi_n_in(nmi_n), .ext_irq_n_in(irq_n), .bus_req_in(breq), .bus_grant_out(bgnt), .halt_n_out(halt_n),
    .onchip_irq_in(onchip), .onchip_comb_irq_in(comb), .clk_gate_out(gates), .clk_div1_out(div1),
    .wake_irq_out(wirq), .wake_resume_out(wres), .dedicated_irq_in(ded), .daisy_req_in(dreq),
    .daisy_ack_in(dack), .irq_level_out(lvl), .irq_pend_out(pend), .daisy_grant_out(dgnt));
  lpmc_far_end far (.clk_in(clk), .src_on_in(src), .bus_want_in(want), .hold_in(hold), .bus_grant_in(bgnt),
    .nmi_n_out(nmi_n), .ext_irq_n_out(irq_n), .bus_req_out(breq));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // k 0: wake pulse, 1: bus grant, 2: bus ready
  task automatic wait_on(input int k, output int c);
    logic [2:0] f;
    for (c = 1; c <= 400; c++)
    begin
      @(posedge clk);
      f = {hrdy, bgnt, wirq | wres};
      if (f[k] === 1'b1)
        return;
    end
    cmp("wait", 1, 0);
    complete_run();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int c;
    req <= '{1'b1, 2'b10, a, w, 3'b010};
    wait_on(2, c);
    req <= '{1'b0, 2'b00, a, 1'b0, 3'b010};
    wdata <= d;
    wait_on(2, c);
    q = hrdata;
  endtask
  task automatic rd_chk(input string w, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    cmp(w, e, q);
  endtask
  task automatic st(input logic [3:0] s);
    ahb(1'b0, `LPMC_OFS_STATUS, 32'h0000_0000);
    cmp("state", s, q[3:0]);
  endtask
  task automatic enter(input logic [31:0] io, input logic [31:0] cpu);
    ahb(1'b1, `LPMC_OFS_IO_CTRL, io);
    ahb(1'b1, `LPMC_OFS_CPU_CTRL, cpu);
    ahb(1'b1, `LPMC_OFS_SLEEP, 32'h0000_0000);
    tick(3);
  endtask
  task automatic wake(input logic [3:0] s, input int lo, input int hi, input logic e);
    src <= s;
    wait_on(0, n);
    cmp("wake time", 1, n >= lo && n <= hi);
    cmp("wake kind", e, wirq);
    src <= 4'h0;
    tick(6);
  endtask
  task automatic mode(input logic [31:0] io, cpu, input logic [3:0] s, input logic [4:0] g, input int lo, hi);
    enter(io, cpu);
    st(s);
    cmp("gates", g, gates);
    wake(4'h8, lo, hi, 1'b1);
  endtask
  initial
  begin
    rst = 1'b1;
    req = '0;
    wdata = 32'h0000_0000;
    src = 4'h0;
    want = 1'b0;
    hold = 4'h5;
    onchip = 1'b0;
    comb = 1'b0;
    ded = 8'h00;
    dreq = 4'h0;
    dack = 1'b0;
    n_fail = 0;
    tests_run = 0;
    tick(12);
    rst <= 1'b0;
    @(posedge clk);
    cmp("div1", 0, div1);
    rd_chk("cpu ctrl", `LPMC_OFS_CPU_CTRL, 32'h0000_0000);
    rd_chk("irq ctrl", `LPMC_OFS_IRQ_CTRL, 32'h0000_0001);
    rd_chk("unmapped", 32'h0000_0040, 32'h0000_0000);
    ahb(1'b1, `LPMC_OFS_CPU_CTRL, 32'h0000_0080);
    tick(2);
    cmp("div1", 1, div1);
    mode(32'h0000_0020, 32'h0000_0000, 4'h2, 5'b11000, 3, 8);
    mode(32'h0000_0000, 32'h0000_0000, 4'h1, 5'b11010, 3, 8);
    mode(32'h0000_0020, 32'h0000_0008, 4'h3, 5'b10000, 11, 15);
    mode(32'h0000_0020, 32'h0000_0040, 4'h6, 5'b00000, 100, 108);
    enter(32'h0000_0020, 32'h0000_0000);
    onchip <= 1'b1;
    tick(20);
    st(4'h2);
    comb <= 1'b1;
    wait_on(0, n);
    cmp("wake kind", 0, wirq);
    onchip <= 1'b0;
    comb <= 1'b0;
    tick(6);
    ahb(1'b1, `LPMC_OFS_GIE, 32'h0000_0001);
    enter(32'h0000_0020, 32'h0000_0008);
    src <= 4'h2;
    tick(20);
    st(4'h3);
    ahb(1'b1, `LPMC_OFS_IRQ_CTRL, 32'h0000_0003);
    wake(4'h2, 1, 16, 1'b1);
    ded <= 8'h01;
    tick(3);
    cmp("level", 4'h3, lvl);
    cmp("pending", 1, pend);
    ded <= 8'h00;
    dreq <= 4'h6;
    tick(3);
    cmp("level", 4'hB, lvl);
    dack <= 1'b1;
    @(posedge clk);
    dack <= 1'b0;
    @(posedge clk);
    cmp("daisy", 5'b00010, dgnt);
    dreq <= 4'h0;
    ahb(1'b1, `LPMC_OFS_GIE, 32'h0000_0000);
    want <= 1'b1;
    wait_on(1, nr);
    want <= 1'b0;
    tick(10);
    enter(32'h0000_0020, 32'h0000_0008);
    want <= 1'b1;
    tick(30);
    cmp("grant", 0, bgnt);
    want <= 1'b0;
    wake(4'h8, 11, 15, 1'b1);
    enter(32'h0000_0020, 32'h0000_0028);
    want <= 1'b1;
    wait_on(1, n);
    cmp("grant delay", 8, n - nr);
    tick(12);
    st(4'h3);
    want <= 1'b0;
    wake(4'h8, 11, 15, 1'b1);
    ahb(1'b1, `LPMC_OFS_IRQ_CTRL, 32'h0000_0005);
    enter(32'h0000_0020, 32'h0000_0048);
    src <= 4'h4;
    tick(20);
    src <= 4'h0;
    tick(80);
    st(4'h6);
    wake(4'h4, 64, 72, 1'b0);
    enter(32'h0000_0020, 32'h0000_0068);
    want <= 1'b1;
    wait_on(1, n);
    cmp("grant delay", 1, n >= 64 && n <= 72);
    tick(12);
    st(4'h6);
    want <= 1'b0;
    wake(4'h8, 64, 72, 1'b1);
    complete_run();
  end
endmodule
